// >>> design/mlb_bus_ctrl.sv
// minimum-mode local bus control: bus state sequencer, strobes and hold handshake
//
// How it works
// - minimum-mode pin behaviour only with mode pin high
// - memory/io select valid from prior T4 onward; here only for back-to-back cycles, else from T1
// - control lines float during hold acknowledge
// - write strobe low in T2, T3, waits
// - interrupt acknowledge strobe low in T2, T3, waits
// - address latch pulse high during T1
// - address latch pulse never floats
// - transceiver enable low on every bus cycle
// - read/intack: enable mid T2 to mid T4
// - write: enable start T2 to mid T4
// - bus floats together with hold grant rise
// - hold low drops grant; redrive on next cycle
// - all state kept while clock stopped
// - works at any clock rate, single stepped
// - active cycle releases at T4 only if allowed
// - idle bus released during the next clock
`timescale 1ns/1ps
`default_nettype none

module mlb_bus_ctrl (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic clk_en,
    // strap and handshake pins
    input  wire logic mode_select_pin,
    input  wire logic hold,
    input  wire logic ready,
    // cycle request from the bus interface core
    input  wire logic req_valid,
    input  wire logic req_mem,
    input  wire logic req_write,
    input  wire logic req_intack,
    input  wire logic req_no_release,
    // request status back to the core
    output var  logic req_taken,
    output var  logic cycle_done,
    // bus control pins with their enables
    output var  logic mem_io_select,
    output var  logic mem_io_select_oe,
    output var  logic write_strobe_n,
    output var  logic write_strobe_n_oe,
    output var  logic intack_strobe_n,
    output var  logic intack_strobe_n_oe,
    output var  logic xcvr_direction,
    output var  logic xcvr_direction_oe,
    output var  logic xcvr_enable_n,
    output var  logic xcvr_enable_n_oe,
    output var  logic addr_latch_pulse,
    output var  logic hold_grant,
    output var  logic bus_drive_en
);

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    mlb_pkg::mlb_state_t state_ff;        // current bus state
    mlb_pkg::mlb_state_t nxt_state;
    logic                phase_ff;        // half of the current state
    logic                nxt_phase;
    logic                drive_ff;        // processor owns the bus
    logic                nxt_drive;
    logic                cyc_mem_ff;      // latched cycle attributes
    logic                nxt_cyc_mem;
    logic                cyc_write_ff;
    logic                nxt_cyc_write;
    logic                cyc_intack_ff;
    logic                nxt_cyc_intack;
    logic                cyc_norel_ff;    // cycle may not give up the bus
    logic                nxt_cyc_norel;
    logic                hold_seen_ff;    // hold seen by end of T2
    logic                nxt_hold_seen;

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic nxt_req_taken;
    logic nxt_cycle_done;
    logic nxt_mio;
    logic nxt_wr_n;
    logic nxt_intack_strobe_n_n;
    logic nxt_dtr;
    logic nxt_den_n;
    logic nxt_ale;
    logic nxt_grant;
    logic nxt_ctl_oe;

    // helper terms
    logic minmode;      // strap says minimum mode
    logic half_end;     // this edge closes a whole bus state
    logic release_ok;   // hold may take the bus at this T4
    logic strobe_win;   // T2, T3 or wait state
    logic den_win;      // transceiver enable window

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // the sequencer advances one half-state per enabled clock; with
    // clk_en low nothing changes, so a stopped or stepped clock keeps
    // every value for as long as it likes
    always_comb begin
        minmode        = mode_select_pin;
        half_end       = (phase_ff == mlb_pkg::PH_MID);
        // same conditions as request/grant: seen by T2, not a locked cycle
        release_ok     = hold_seen_ff && !cyc_norel_ff;
        nxt_state      = state_ff;
        nxt_phase      = phase_ff;
        nxt_drive      = drive_ff;
        nxt_cyc_mem    = cyc_mem_ff;
        nxt_cyc_write  = cyc_write_ff;
        nxt_cyc_intack = cyc_intack_ff;
        nxt_cyc_norel  = cyc_norel_ff;
        nxt_hold_seen  = hold_seen_ff;
        // pulses keep their value too while the clock is stopped
        nxt_req_taken  = req_taken;
        nxt_cycle_done = cycle_done;
        if (clk_en) begin
            nxt_phase      = !phase_ff;
            nxt_req_taken  = mlb_pkg::RST_LOW;
            nxt_cycle_done = mlb_pkg::RST_LOW;
            // hold is used as it arrives; the requester keeps it synchronous
            if ((state_ff == mlb_pkg::MLB_T1 || state_ff == mlb_pkg::MLB_T2) && hold) begin
                nxt_hold_seen = 1'b1;
            end
            case (state_ff)
                mlb_pkg::MLB_IDLE: begin
                    if (!half_end && hold) begin
                        // idle bus: grant in the second half of this clock
                        nxt_state = mlb_pkg::MLB_HOLDA;
                        nxt_drive = 1'b0;
                    end else if (half_end && req_valid) begin
                        nxt_state      = mlb_pkg::MLB_T1;
                        nxt_drive      = 1'b1;
                        nxt_cyc_mem    = req_mem && !req_intack;
                        nxt_cyc_write  = req_write && !req_intack;
                        nxt_cyc_intack = req_intack;
                        nxt_cyc_norel  = req_no_release;
                        nxt_hold_seen  = 1'b0;
                        nxt_req_taken  = 1'b1;
                    end
                end
                mlb_pkg::MLB_T1: begin
                    if (half_end) begin
                        nxt_state = mlb_pkg::MLB_T2;
                    end
                end
                mlb_pkg::MLB_T2: begin
                    if (half_end) begin
                        nxt_state = mlb_pkg::MLB_T3;
                    end
                end
                mlb_pkg::MLB_T3, mlb_pkg::MLB_TW: begin
                    // ready is looked at only when a state closes
                    if (half_end) begin
                        nxt_state = ready ? mlb_pkg::MLB_T4 : mlb_pkg::MLB_TW;
                    end
                end
                mlb_pkg::MLB_T4: begin
                    if (!half_end && !release_ok && req_valid) begin
                        // next cycle type shows already in this T4
                        nxt_cyc_mem   = req_mem && !req_intack;
                        nxt_cyc_write = req_write && !req_intack;
                    end
                    if (half_end) begin
                        nxt_cycle_done = 1'b1;
                        if (release_ok) begin
                            nxt_state = mlb_pkg::MLB_IDLE;
                        end else if (req_valid) begin
                            nxt_state      = mlb_pkg::MLB_T1;
                            nxt_cyc_mem    = req_mem && !req_intack;
                            nxt_cyc_write  = req_write && !req_intack;
                            nxt_cyc_intack = req_intack;
                            nxt_cyc_norel  = req_no_release;
                            nxt_hold_seen  = 1'b0;
                            nxt_req_taken  = 1'b1;
                        end else begin
                            nxt_state = mlb_pkg::MLB_IDLE;
                        end
                    end
                end
                mlb_pkg::MLB_HOLDA: begin
                    // grant stays until hold is seen low at a state end
                    if (half_end && !hold) begin
                        nxt_state = mlb_pkg::MLB_IDLE;
                    end
                end
                default: begin
                    nxt_state = mlb_pkg::RST_STATE;
                    nxt_phase = mlb_pkg::RST_PHASE;
                end
            endcase
            // maximum mode: sequencer parks, no cycle, no grant
            if (!minmode) begin
                nxt_state      = mlb_pkg::MLB_IDLE;
                nxt_phase      = mlb_pkg::RST_PHASE;
                nxt_drive      = mlb_pkg::RST_DRIVE;
                nxt_req_taken  = 1'b0;
                nxt_cycle_done = 1'b0;
            end
        end

        // pin values follow the next state so the flops line up with it
        strobe_win = (nxt_state == mlb_pkg::MLB_T2) || (nxt_state == mlb_pkg::MLB_T3)
                     || (nxt_state == mlb_pkg::MLB_TW);
        // writes open at T2 start, reads and intack at mid T2; all shut mid T4
        den_win    = (strobe_win && !(nxt_state == mlb_pkg::MLB_T2
                                      && nxt_phase == mlb_pkg::PH_FIRST && !nxt_cyc_write))
                     || (nxt_state == mlb_pkg::MLB_T4 && nxt_phase == mlb_pkg::PH_FIRST);
        nxt_ale    = (nxt_state == mlb_pkg::MLB_T1) && minmode;
        nxt_wr_n   = !(strobe_win && nxt_cyc_write);
        nxt_intack_strobe_n_n = !(strobe_win && nxt_cyc_intack);
        nxt_den_n  = !den_win;
        nxt_mio    = nxt_cyc_mem;
        nxt_dtr    = nxt_cyc_write;
        nxt_grant  = (nxt_state == mlb_pkg::MLB_HOLDA);
        nxt_ctl_oe = nxt_drive && minmode && (nxt_state != mlb_pkg::MLB_HOLDA);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // only constants under reset; every pin is a flop output
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff           <= mlb_pkg::RST_STATE;
            phase_ff           <= mlb_pkg::RST_PHASE;
            drive_ff           <= mlb_pkg::RST_DRIVE;
            cyc_mem_ff         <= mlb_pkg::RST_LOW;
            cyc_write_ff       <= mlb_pkg::RST_LOW;
            cyc_intack_ff      <= mlb_pkg::RST_LOW;
            cyc_norel_ff       <= mlb_pkg::RST_LOW;
            hold_seen_ff       <= mlb_pkg::RST_LOW;
            req_taken          <= mlb_pkg::RST_LOW;
            cycle_done         <= mlb_pkg::RST_LOW;
            mem_io_select      <= mlb_pkg::RST_LOW;
            write_strobe_n     <= mlb_pkg::RST_STRB;
            intack_strobe_n    <= mlb_pkg::RST_STRB;
            xcvr_direction     <= mlb_pkg::RST_LOW;
            xcvr_enable_n      <= mlb_pkg::RST_STRB;
            addr_latch_pulse   <= mlb_pkg::RST_LOW;
            hold_grant         <= mlb_pkg::RST_LOW;
            mem_io_select_oe   <= mlb_pkg::RST_LOW;
            write_strobe_n_oe  <= mlb_pkg::RST_LOW;
            intack_strobe_n_oe <= mlb_pkg::RST_LOW;
            xcvr_direction_oe  <= mlb_pkg::RST_LOW;
            xcvr_enable_n_oe   <= mlb_pkg::RST_LOW;
            bus_drive_en       <= mlb_pkg::RST_LOW;
        end else begin
            state_ff           <= nxt_state;
            phase_ff           <= nxt_phase;
            drive_ff           <= nxt_drive;
            cyc_mem_ff         <= nxt_cyc_mem;
            cyc_write_ff       <= nxt_cyc_write;
            cyc_intack_ff      <= nxt_cyc_intack;
            cyc_norel_ff       <= nxt_cyc_norel;
            hold_seen_ff       <= nxt_hold_seen;
            req_taken          <= nxt_req_taken;
            cycle_done         <= nxt_cycle_done;
            mem_io_select      <= nxt_mio;
            write_strobe_n     <= nxt_wr_n;
            intack_strobe_n    <= nxt_intack_strobe_n_n;
            xcvr_direction     <= nxt_dtr;
            xcvr_enable_n      <= nxt_den_n;
            addr_latch_pulse   <= nxt_ale;      // no enable: always driven
            hold_grant         <= nxt_grant;
            mem_io_select_oe   <= nxt_ctl_oe;
            write_strobe_n_oe  <= nxt_ctl_oe;
            intack_strobe_n_oe <= nxt_ctl_oe;
            xcvr_direction_oe  <= nxt_ctl_oe;
            xcvr_enable_n_oe   <= nxt_ctl_oe;
            bus_drive_en       <= nxt_ctl_oe;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_MODE_FLOAT: assert property (!mode_select_pin && clk_en |=> !mem_io_select_oe)
        else $error("control pins driven outside minimum mode");
    AST_HOLD_FLOAT: assert property (hold_grant |-> !mem_io_select_oe && !write_strobe_n_oe
                                     && !xcvr_direction_oe && !xcvr_enable_n_oe)
        else $error("control line driven during hold acknowledge");
    AST_WR_WINDOW: assert property (!write_strobe_n |-> cyc_write_ff
                                    && state_ff inside {mlb_pkg::MLB_T2, mlb_pkg::MLB_T3,
                                                        mlb_pkg::MLB_TW})
        else $error("write strobe outside T2..Tw of a write");
    AST_INTACK_STROBE_N_T3: assert property (state_ff == mlb_pkg::MLB_T3 && cyc_intack_ff
                                  |-> !intack_strobe_n)
        else $error("intack strobe missing in T3");
    AST_ALE_T1: assert property ($rose(addr_latch_pulse) |-> state_ff == mlb_pkg::MLB_T1
                                 && phase_ff == mlb_pkg::PH_FIRST)
        else $error("address latch pulse outside T1");
    AST_DEN_READ: assert property (state_ff == mlb_pkg::MLB_T2 && phase_ff == mlb_pkg::PH_FIRST
                                   && !cyc_write_ff |-> xcvr_enable_n)
        else $error("read enable before middle of T2");
    AST_DEN_WRITE: assert property (state_ff == mlb_pkg::MLB_T2 && cyc_write_ff
                                    |-> !xcvr_enable_n)
        else $error("write enable missing at start of T2");
    AST_DEN_END: assert property (state_ff == mlb_pkg::MLB_T4 && phase_ff == mlb_pkg::PH_MID
                                  |-> xcvr_enable_n)
        else $error("transceiver enable past middle of T4");
    AST_GRANT_MID: assert property ($rose(hold_grant) |-> phase_ff == mlb_pkg::PH_MID
                                    && !bus_drive_en)
        else $error("hold grant not at mid clock with bus floated");
    AST_GRANT_DROP: assert property (hold_grant && phase_ff == mlb_pkg::PH_MID && !hold
                                     && clk_en && mode_select_pin |=> !hold_grant)
        else $error("hold grant kept after hold low");
    AST_IDLE_GRANT: assert property (state_ff == mlb_pkg::MLB_IDLE && phase_ff == mlb_pkg::PH_FIRST
                                     && hold && clk_en && mode_select_pin |=> hold_grant)
        else $error("idle bus not released within the clock");
    AST_NO_RELEASE: assert property (state_ff == mlb_pkg::MLB_T4 && phase_ff == mlb_pkg::PH_MID
                                     && cyc_norel_ff && req_valid && clk_en && mode_select_pin
                                     |=> state_ff == mlb_pkg::MLB_T1)
        else $error("locked cycle released the bus");
    AST_T3_NEXT: assert property (state_ff == mlb_pkg::MLB_T3 |=> state_ff inside
                                  {mlb_pkg::MLB_T3, mlb_pkg::MLB_TW, mlb_pkg::MLB_T4})
        else $error("T3 not followed by T3, Tw or T4");

endmodule

`default_nettype wire

// >>> design/mlb_pkg.sv
// shared constants and types for the minimum-mode local bus control block
package mlb_pkg;

    // ------------------------------------------------------------
    // bus state sequencer
    // ------------------------------------------------------------
    // each bus state spans two clocks: phase 0 is the first half, phase 1
    // the second, so "middle of a state" is the edge into phase 1
    typedef enum logic [2:0] {
        MLB_IDLE  = 3'h0,   // idle state, no cycle; bus owned except after a hold, until the next T1
        MLB_T1    = 3'h1,   // address state
        MLB_T2    = 3'h2,   // strobe start
        MLB_T3    = 3'h3,   // ready sample
        MLB_TW    = 3'h4,   // wait state
        MLB_T4    = 3'h5,   // cycle end
        MLB_HOLDA = 3'h6    // bus handed to another master
    } mlb_state_t;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam mlb_state_t RST_STATE = MLB_IDLE;
    localparam logic       RST_PHASE = 1'b0;   // first half of a state
    localparam logic       RST_DRIVE = 1'b1;   // processor owns the bus
    localparam logic       RST_STRB  = 1'b1;   // active-low strobes idle
    localparam logic       RST_LOW   = 1'b0;   // plain low outputs
    localparam logic       PH_FIRST  = 1'b0;   // phase code, first half
    localparam logic       PH_MID    = 1'b1;   // phase code, second half

endpackage

// >>> test/min_mode_local_bus_control_test.sv
// self-checking bench for the minimum-mode local bus control
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module min_mode_local_bus_control_test;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       clock, reset, clk_en, mode_select_pin, hold, ready;  // clock, strap, handshake
    logic       req_valid, req_mem, req_write, req_intack, req_no_release;  // core request
    logic       req_taken, cycle_done, hold_grant, bus_drive_en, addr_latch_pulse;
    logic       mem_io_select, write_strobe_n, intack_strobe_n, xcvr_direction, xcvr_enable_n;
    logic [4:0] oe;           // enables of the five floating pins
    logic       hold_req;     // asks the far master to take the bus
    logic [3:0] wait_states;  // waits the far device inserts
    int         fail_count, n_tests, n_clk;

    mlb_bus_ctrl i_dut (
        .clock(clock), .reset(reset), .clk_en(clk_en), .mode_select_pin(mode_select_pin),
        .hold(hold), .ready(ready), .req_valid(req_valid), .req_mem(req_mem),
        .req_write(req_write), .req_intack(req_intack), .req_no_release(req_no_release),
        .req_taken(req_taken), .cycle_done(cycle_done), .mem_io_select(mem_io_select),
        .mem_io_select_oe(oe[0]), .write_strobe_n(write_strobe_n), .write_strobe_n_oe(oe[1]),
        .intack_strobe_n(intack_strobe_n), .intack_strobe_n_oe(oe[2]),
        .xcvr_direction(xcvr_direction), .xcvr_direction_oe(oe[3]),
        .xcvr_enable_n(xcvr_enable_n), .xcvr_enable_n_oe(oe[4]),
        .addr_latch_pulse(addr_latch_pulse), .hold_grant(hold_grant),
        .bus_drive_en(bus_drive_en));

    mlb_far_side i_far (
        .clock(clock), .reset(reset), .addr_latch_pulse(addr_latch_pulse),
        .hold_req(hold_req), .wait_states(wait_states), .ready(ready), .hold(hold));

    // ------------------------------------------------------------
    // clock, timeout and verdict
    // ------------------------------------------------------------
    always #4 clock = ~clock;

    // whole run is a few hundred clocks; the ceiling leaves wide margin
    always @(posedge clock) begin
        n_clk++;
        if (n_clk == 5000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // raise a request and wait, bounded, until the device takes it
    task automatic request(input logic m, input logic w, input logic ia, input logic nr);
        int k;
        req_mem = m;
        req_write = w;
        req_intack = ia;
        req_no_release = nr;
        req_valid = 1'b1;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (req_taken !== 1'b1 && k < 40);
        `CHK(req_taken, 1'b1)
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // one cycle, every pin except hold_grant compared clock by clock against its window
    task automatic bus_cycle(input logic m, input logic w, input logic ia, input logic [3:0] ws);
        int         t4;
        logic [7:0] exp;
        logic [7:0] got;
        wait_states <= ws;
        request(m, w, ia, 1'b0);
        req_valid = 1'b0;
        t4 = 6 + 2 * ws;
        for (int i = 0; i <= t4 + 2; i++) begin
            if (i > 0) @(negedge clock);
            exp = {i == t4 + 2, i < 2, m & ~ia, w, ~(i >= (w ? 2 : 3) && i <= t4),
                   ~(ia && i >= 2 && i < t4), ~(w && i >= 2 && i < t4), 1'b1};
            got = {cycle_done, addr_latch_pulse, mem_io_select, xcvr_direction,
                   xcvr_enable_n, intack_strobe_n, write_strobe_n, bus_drive_en & (&oe)};
            `CHK(got, exp)
        end
    endtask

    // hold while idle: grant, float, refuse, give back, redrive
    task automatic hold_idle();
        int k;
        int taken;
        hold_req <= 1'b1;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (hold_grant !== 1'b1 && k < 8);
        `CHK(k <= 4, 1'b1)
        `CHK({oe, bus_drive_en, addr_latch_pulse}, 7'h00)
        req_valid = 1'b1;
        taken = 0;
        repeat (8) begin
            @(negedge clock);
            taken += req_taken;
        end
        `CHK(taken, 0)
        req_valid = 1'b0;
        hold_req <= 1'b0;
        tick(4);
        `CHK({hold_grant, oe, bus_drive_en}, 7'h00)
        bus_cycle(1'b1, 1'b0, 1'b0, 4'h0);
    endtask

    // hold in T1 with a second request pending
    task automatic hold_mid(input logic nr);
        int taken;
        int grant;
        request(1'b1, 1'b0, 1'b0, nr);
        hold_req <= 1'b1;
        taken = 0;
        grant = 0;
        repeat (12) begin
            @(negedge clock);
            taken += req_taken;
            grant |= hold_grant;
        end
        `CHK({taken[1:0], grant[0]}, nr ? 3'b010 : 3'b001)
        req_valid = 1'b0;
        hold_req <= 1'b0;
        tick(30);
        `CHK(hold_grant, 1'b0)
    endtask

    // stopped clock keeps T2, then single steps finish the cycle
    task automatic freeze();
        request(1'b0, 1'b1, 1'b0, 1'b0);
        req_valid = 1'b0;
        tick(2);
        clk_en = 1'b0;
        tick(20);
        `CHK({addr_latch_pulse, write_strobe_n, xcvr_enable_n}, 3'b000)
        repeat (6) begin
            clk_en = 1'b1;
            tick(1);
            clk_en = 1'b0;
            tick(3);
        end
        `CHK({cycle_done, write_strobe_n, xcvr_enable_n}, 3'b111)
        clk_en = 1'b1;
        tick(2);
    endtask

    // mode pin low parks the block with nothing driven
    task automatic mode_low();
        mode_select_pin = 1'b0;
        req_valid = 1'b1;
        tick(6);
        `CHK({oe, bus_drive_en, addr_latch_pulse, req_taken}, 8'h00)
        req_valid = 1'b0;
        mode_select_pin = 1'b1;
        tick(4);
        `CHK(bus_drive_en, 1'b1)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {clock, reset, clk_en, mode_select_pin} = 4'b0111;
        {req_valid, req_mem, req_write, req_intack, req_no_release} = 5'h00;
        hold_req = 1'b0;
        wait_states = 4'h0;
        fail_count = 0;
        n_tests = 0;
        n_clk = 0;
        tick(16);
        `CHK({oe, bus_drive_en, addr_latch_pulse, hold_grant}, 8'h00)
        `CHK({write_strobe_n, intack_strobe_n, xcvr_enable_n}, 3'h7)
        reset = 1'b0;
        tick(2);
        `CHK(bus_drive_en, 1'b1)
        bus_cycle(1'b1, 1'b1, 1'b0, 4'h0);
        bus_cycle(1'b0, 1'b0, 1'b0, 4'h1);
        bus_cycle(1'b0, 1'b0, 1'b1, 4'h0);
        bus_cycle(1'b1, 1'b0, 1'b0, 4'h2);
        bus_cycle(1'b0, 1'b1, 1'b0, 4'h1);
        wait_states <= 4'h0;
        hold_idle();
        hold_mid(1'b0);
        hold_mid(1'b1);
        freeze();
        mode_low();
        finish_test();
    end
endmodule
`default_nettype wire

// >>> test/mlb_far_side.sv
// far side model: slow memory or io device and a second bus master
`timescale 1ns/1ps
`default_nettype none

module mlb_far_side (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // seen from the device
    input  wire logic       addr_latch_pulse,
    // bench controls
    input  wire logic       hold_req,
    input  wire logic [3:0] wait_states,
    // lines back to the device
    output var  logic       ready,
    output var  logic       hold
);
    // ------------------------------------------------------------
    // ready timing and hold request
    // ------------------------------------------------------------
    logic [5:0] since_ale_ff;   // clocks since the address pulse ended
    logic [5:0] nxt_since_ale;  // saturates so idle keeps ready high

    // count from the end of the address pulse
    always_comb begin
        nxt_since_ale = since_ale_ff + 6'h01;
        if (addr_latch_pulse) begin
            nxt_since_ale = 6'h00;
        end else if (since_ale_ff == 6'h3f) begin
            nxt_since_ale = since_ale_ff;
        end
    end

    // falling edge drive keeps set-up to the device's rising edge
    always_ff @(negedge clock or posedge reset) begin
        if (reset) begin
            since_ale_ff <= 6'h3f;
            ready        <= 1'b1;
            hold         <= 1'b0;
        end else begin
            since_ale_ff <= nxt_since_ale;
            // low through T3 and all asked waits but the last, whichever half is sampled
            ready <= (wait_states == 4'h0) || (nxt_since_ale >= {1'b0, wait_states, 1'b0} + 6'h03);
            hold  <= hold_req;
        end
    end
endmodule
`default_nettype wire
